// >>> rtl/auto_reload_timer_lfo_capture.sv
// Summary of operation
// - two byte counters form one 16-bit value; split bit picks 16 or 2x8.
// - clocks: system, system/12, external/8, low-frequency oscillator/8.
// - external and oscillator sources synchronised, except in suspend: direct.
// - 16-bit or high byte overflow during suspend pulses the wake output.
// - after other wake, sync pending flag stands for three timer clocks.
// - oscillator/8 source counts only when its divider is set to one.
// - 16-bit overflow sets high flag; it loads reload pair only outside capture mode.
// - 16-bit mode with timer irq enabled interrupts on each overflow.
// - 16-bit mode, low irq enable adds low byte wrap interrupts.
// - split mode: each byte counts and reloads from its own reload byte.
// - split mode: run bit gates high byte only; low byte always counts.
// - sysclk select bit per byte, else alternate field picks the clock.
// - split mode: each byte wrap sets its own overflow flag.
// - split mode irq on high wrap; with low enable, on either wrap.
// - hardware never clears flags; software clears them.
// - capture enable puts full 16-bit counter in oscillator capture mode.
// - capture: oscillator falling edge copies counter to reload, sets flag.
// - control register layout bits 7..0, all read/write, reset zero.
module auto_reload_timer_lfo_capture (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // clock sources and power state
    input wire logic ext_clk_i,
    input wire logic lfo_clk_i,
    input wire logic lfo_div_one_i,
    input wire logic suspend_i,
    input wire logic other_wake_i,
    // events
    output logic irq_o,
    output logic wake_o,
    output logic sync_pending_flag_o
);
    logic [7:0] timer_control_reg_q;
    logic [2:0] clkcfg_q;
    logic [7:0] reload_low_byte_q;
    logic [7:0] reload_high_byte_q;
    logic [7:0] count_low_byte_q;
    logic [7:0] count_high_byte_q;
    logic sync_pending_flag_q;
    logic [1:0] sync_cnt_q;
    logic wake_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    logic sys12_tick;
    logic [1:0] src8_tick;
    logic lfo_fall;
    logic alt_tick;
    logic low_tick;
    logic high_tick;
    logic split;
    logic capture;
    logic run;
    logic low_en;
    logic high_en;
    logic low_wrap;
    logic high_wrap;
    logic wide_wrap;
    logic set_high_flag;
    logic set_low_flag;
    logic acc_setup;
    logic wr_en;
    logic count_addr;
    logic mapped;

    clock_tick_gen u_ticks (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .suspend_i(suspend_i),
        .src_i({lfo_clk_i, ext_clk_i}),
        .sys12_tick_o(sys12_tick),
        .src8_tick_o(src8_tick),
        .lfo_fall_o(lfo_fall)
    );

    assign split = timer_control_reg_q[timer_pkg::SPLIT_BIT];
    assign capture = timer_control_reg_q[timer_pkg::CAPTURE_EN_BIT];
    assign run = timer_control_reg_q[timer_pkg::RUN_BIT];

    // alternate clock mux; the reserved code never ticks
    always_comb
    begin
        case (timer_control_reg_q[timer_pkg::ALT_CLK_MSB:
                                  timer_pkg::ALT_CLK_LSB])
            timer_pkg::ALT_SYS12: alt_tick = sys12_tick;
            timer_pkg::ALT_EXT8: alt_tick = src8_tick[0];
            timer_pkg::ALT_LFO: alt_tick = src8_tick[1] && lfo_div_one_i;
            timer_pkg::ALT_RSVD: alt_tick = 1'b0;
            default: alt_tick = 1'b0;
        endcase
    end

    assign low_tick = clkcfg_q[timer_pkg::LOW_SYSCLK_BIT] ? ce_i
                                                          : alt_tick;
    assign high_tick = clkcfg_q[timer_pkg::HIGH_SYSCLK_BIT] ? ce_i
                                                            : alt_tick;

    // the 16-bit counter runs on the low byte clock selection
    assign low_en = split ? low_tick : (low_tick && run);
    assign high_en = split ? (high_tick && run) : low_en;
    assign low_wrap = low_en && (count_low_byte_q == timer_pkg::BYTE_MAX);
    assign wide_wrap = !split && low_wrap
                       && (count_high_byte_q == timer_pkg::BYTE_MAX);
    assign high_wrap = split ? (high_en
                               && (count_high_byte_q == timer_pkg::BYTE_MAX))
                             : wide_wrap;

    assign set_high_flag = high_wrap || (capture && lfo_fall);
    assign set_low_flag = low_wrap;

    // apb decode; decode in setup so read data is a flop in the access phase
    assign acc_setup = psel_i && !penable_i;
    assign wr_en = ce_i && psel_i && penable_i && pwrite_i && !pslverr_q;
    assign count_addr = (paddr_i == timer_pkg::COUNT_LO_OFF)
                        || (paddr_i == timer_pkg::COUNT_HI_OFF);
    assign mapped = (paddr_i == timer_pkg::CTRL_OFF)
                    || (paddr_i == timer_pkg::RELOAD_LO_OFF)
                    || (paddr_i == timer_pkg::RELOAD_HI_OFF)
                    || count_addr
                    || (paddr_i == timer_pkg::CLKCFG_OFF)
                    || (paddr_i == timer_pkg::STATUS_OFF);

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (ce_i && acc_setup)
        begin
            // count bytes are refused while the sync is still pending
            pslverr_q <= !mapped || (count_addr && sync_pending_flag_q);
            case (paddr_i)
                timer_pkg::CTRL_OFF:
                    prdata_q <= {24'h000000, timer_control_reg_q};
                timer_pkg::RELOAD_LO_OFF:
                    prdata_q <= {24'h000000, reload_low_byte_q};
                timer_pkg::RELOAD_HI_OFF:
                    prdata_q <= {24'h000000, reload_high_byte_q};
                timer_pkg::COUNT_LO_OFF:
                    prdata_q <= {24'h000000, count_low_byte_q};
                timer_pkg::COUNT_HI_OFF:
                    prdata_q <= {24'h000000, count_high_byte_q};
                timer_pkg::CLKCFG_OFF:
                    prdata_q <= {29'h0, clkcfg_q};
                timer_pkg::STATUS_OFF:
                    prdata_q <= {30'h0, lfo_div_one_i,
                                 sync_pending_flag_q};
                default:
                    prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && pslverr_q;

    // control register; hardware flag sets win over a software clear
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            timer_control_reg_q <= timer_pkg::CTRL_RESET;
        else if (ce_i)
        begin
            if (wr_en && (paddr_i == timer_pkg::CTRL_OFF))
                timer_control_reg_q <= pwdata_i[7:0];
            if (set_high_flag)
                timer_control_reg_q[timer_pkg::HIGH_FLAG_BIT] <= 1'b1;
            if (set_low_flag)
                timer_control_reg_q[timer_pkg::LOW_FLAG_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            clkcfg_q <= timer_pkg::CLKCFG_RESET;
        else if (wr_en && (paddr_i == timer_pkg::CLKCFG_OFF))
            clkcfg_q <= pwdata_i[2:0];
    end

    // reload pair: software write, or capture of the live count
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            reload_low_byte_q <= 8'h00;
            reload_high_byte_q <= 8'h00;
        end
        else if (ce_i)
        begin
            if (capture && lfo_fall)
            begin
                reload_low_byte_q <= count_low_byte_q;
                reload_high_byte_q <= count_high_byte_q;
            end
            else if (wr_en && (paddr_i == timer_pkg::RELOAD_LO_OFF))
                reload_low_byte_q <= pwdata_i[7:0];
            else if (wr_en && (paddr_i == timer_pkg::RELOAD_HI_OFF))
                reload_high_byte_q <= pwdata_i[7:0];
        end
    end

    // low byte; a software write takes precedence over that tick's count
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            count_low_byte_q <= 8'h00;
        else if (wr_en && (paddr_i == timer_pkg::COUNT_LO_OFF))
            count_low_byte_q <= pwdata_i[7:0];
        else if (low_en)
        begin
            if (split && low_wrap)
                count_low_byte_q <= reload_low_byte_q;
            else if (wide_wrap && !capture)
                count_low_byte_q <= reload_low_byte_q;
            else
                count_low_byte_q <= count_low_byte_q + 8'h01;
        end
    end

    // high byte; in 16-bit mode it carries on a low byte wrap
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            count_high_byte_q <= 8'h00;
        else if (wr_en && (paddr_i == timer_pkg::COUNT_HI_OFF))
            count_high_byte_q <= pwdata_i[7:0];
        else if (split)
        begin
            if (high_wrap)
                count_high_byte_q <= reload_high_byte_q;
            else if (high_en)
                count_high_byte_q <= count_high_byte_q + 8'h01;
        end
        else if (wide_wrap && !capture)
            count_high_byte_q <= reload_high_byte_q;
        else if (low_wrap)
            count_high_byte_q <= count_high_byte_q + 8'h01;
    end

    // sync pending after a wake that did not come from the timer
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            sync_pending_flag_q <= 1'b0;
            sync_cnt_q <= 2'h0;
        end
        else if (ce_i)
        begin
            if (other_wake_i && suspend_i)
            begin
                sync_pending_flag_q <= 1'b1;
                sync_cnt_q <= 2'h0;
            end
            else if (sync_pending_flag_q && low_tick)
            begin
                if (sync_cnt_q == timer_pkg::SYNC_CLOCKS - 2'h1)
                    sync_pending_flag_q <= 1'b0;
                sync_cnt_q <= sync_cnt_q + 2'h1;
            end
        end
    end

    assign sync_pending_flag_o = sync_pending_flag_q;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            wake_q <= 1'b0;
        else if (ce_i)
            wake_q <= suspend_i && high_wrap;
    end

    assign wake_o = wake_q;

    // level interrupt, held until software clears the flag
    assign irq_o = clkcfg_q[timer_pkg::TIMER_IRQ_EN_BIT]
                   && (timer_control_reg_q[timer_pkg::HIGH_FLAG_BIT]
                       || (timer_control_reg_q[timer_pkg::LOW_IRQ_EN_BIT]
                           && timer_control_reg_q[timer_pkg::LOW_FLAG_BIT]));
endmodule : auto_reload_timer_lfo_capture

// >>> rtl/timer_pkg.sv
package timer_pkg;
    // register byte offsets on the bus
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] RELOAD_LO_OFF = 12'h004;
    localparam logic [11:0] RELOAD_HI_OFF = 12'h008;
    localparam logic [11:0] COUNT_LO_OFF = 12'h00c;
    localparam logic [11:0] COUNT_HI_OFF = 12'h010;
    localparam logic [11:0] CLKCFG_OFF = 12'h014;
    localparam logic [11:0] STATUS_OFF = 12'h018;
    // timer_control_reg fields
    localparam int HIGH_FLAG_BIT = 7;
    localparam int LOW_FLAG_BIT = 6;
    localparam int LOW_IRQ_EN_BIT = 5;
    localparam int CAPTURE_EN_BIT = 4;
    localparam int SPLIT_BIT = 3;
    localparam int RUN_BIT = 2;
    localparam int ALT_CLK_MSB = 1;
    localparam int ALT_CLK_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // clock config fields (clock_control_reg and ext_irq_enable_reg bits)
    localparam int LOW_SYSCLK_BIT = 0;
    localparam int HIGH_SYSCLK_BIT = 1;
    localparam int TIMER_IRQ_EN_BIT = 2;
    localparam logic [2:0] CLKCFG_RESET = 3'h0;
    // status fields
    localparam int SYNC_PENDING_BIT = 0;
    localparam int LFO_DIV_OK_BIT = 1;
    // alternate clock codes
    localparam logic [1:0] ALT_SYS12 = 2'h0;
    localparam logic [1:0] ALT_EXT8 = 2'h1;
    localparam logic [1:0] ALT_RSVD = 2'h2;
    localparam logic [1:0] ALT_LFO = 2'h3;
    // dividers and timing
    localparam int SYS_DIV = 12;
    localparam int SRC_DIV = 8;
    localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
    localparam logic [2:0] SRC_DIV_LAST = 3'(SRC_DIV - 1);
    localparam logic [1:0] SYNC_CLOCKS = 2'h3;
    localparam logic [7:0] BYTE_MAX = 8'hff;
endpackage : timer_pkg

// >>> rtl/clock_tick_gen.sv
module clock_tick_gen (
    // clock and control
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic suspend_i,
    // raw sources: index 0 external clock, 1 low-frequency oscillator
    input wire logic [1:0] src_i,
    // one-cycle ticks
    output logic sys12_tick_o,
    output logic [1:0] src8_tick_o,
    output logic lfo_fall_o
);
    logic [3:0] pre_q;
    logic [1:0] fall_raw;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            pre_q <= 4'h0;
        else if (ce_i)
            pre_q <= (pre_q == timer_pkg::SYS_DIV_LAST) ? 4'h0 : pre_q + 4'h1;
    end

    assign sys12_tick_o = ce_i && (pre_q == timer_pkg::SYS_DIV_LAST);

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_src
            logic s1_q;
            logic s2_q;
            logic prev_q;
            logic raw_prev_q;
            logic [2:0] div_q;
            logic edge_rise;
            always_ff @(posedge core_clk_i)
            begin
                if (!rst_n_i)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    prev_q <= 1'b0;
                    raw_prev_q <= 1'b0;
                end
                else if (ce_i)
                begin
                    s1_q <= src_i[g];
                    s2_q <= s1_q;
                    prev_q <= s2_q;
                    raw_prev_q <= src_i[g];
                end
            end
            // suspend bypasses the synchroniser so the source steers directly
            assign edge_rise = suspend_i ? (src_i[g] && !raw_prev_q)
                                         : (s2_q && !prev_q);
            always_ff @(posedge core_clk_i)
            begin
                if (!rst_n_i)
                    div_q <= 3'h0;
                else if (ce_i && edge_rise)
                    div_q <= div_q + 3'h1;
            end
            assign src8_tick_o[g] = ce_i && edge_rise
                                    && (div_q == timer_pkg::SRC_DIV_LAST);
            assign fall_raw[g] = suspend_i ? (!src_i[g] && raw_prev_q)
                                           : (!s2_q && prev_q);
        end
    endgenerate

    assign lfo_fall_o = ce_i && fall_raw[1];
endmodule : clock_tick_gen

// >>> tb/timer_properties.sv
module timer_properties (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // power state and events
    input wire logic lfo_div_one_i,
    input wire logic suspend_i,
    input wire logic other_wake_i,
    input wire logic wake_o,
    input wire logic sync_pending_flag_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic acc;
    logic bad;
    assign acc = psel_i && penable_i;
    assign bad = paddr_i > timer_pkg::STATUS_OFF || paddr_i[1:0] != 2'h0;
    a_ready_const: assert property (pready_o)
        else $error("pready low");
    a_err_unmapped: assert property (acc && ce_i && bad |-> pslverr_o)
        else $error("no error on unmapped access");
    a_rd_unmapped: assert property (acc && !pwrite_i && bad |-> prdata_o == 0)
        else $error("unmapped read not zero");
    a_err_idle: assert property (!acc |-> !pslverr_o)
        else $error("error outside access");
    a_err_ctrl: assert property (
        acc && paddr_i == timer_pkg::CTRL_OFF |-> !pslverr_o)
        else $error("control access refused");
    a_status_read: assert property (
        acc && !pwrite_i && paddr_i == timer_pkg::STATUS_OFF
        |-> prdata_o[1] == $past(lfo_div_one_i) && prdata_o[31:2] == 0)
        else $error("status read wrong");
    a_wake_cause: assert property (wake_o |-> $past(suspend_i))
        else $error("wake outside suspend");
    a_wake_pulse: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    a_sync_cause: assert property (
        $rose(sync_pending_flag_o) |-> $past(other_wake_i && suspend_i))
        else $error("sync flag without wake");
    a_sync_set: assert property (
        other_wake_i && suspend_i && ce_i |=> sync_pending_flag_o)
        else $error("sync flag not set");
    a_sync_err: assert property (
        acc && sync_pending_flag_o && $past(sync_pending_flag_o)
        && paddr_i == timer_pkg::COUNT_LO_OFF |-> pslverr_o)
        else $error("count access allowed while pending");
endmodule : timer_properties

// >>> tb/testbench.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i = 0, rst_n_i = 0, ce_i = 1;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, rd_data, d0;
    logic pready_o, pslverr_o, rd_err, irq_o, wake_o, sync_pending_flag_o;
    logic ext_clk_i = 0, lfo_clk_i = 0, lfo_div_one_i = 1;
    logic suspend_i = 0, other_wake_i = 0;
    int n_checks = 0, n_mismatch = 0, n_wake = 0, cyc = 0;
    auto_reload_timer_lfo_capture auto_reload_timer_lfo_capture_i (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clk_i(ext_clk_i),
        .lfo_clk_i(lfo_clk_i), .lfo_div_one_i(lfo_div_one_i),
        .suspend_i(suspend_i), .other_wake_i(other_wake_i), .irq_o(irq_o),
        .wake_o(wake_o), .sync_pending_flag_o(sync_pending_flag_o));
    initial
    begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    // a hang in a handshake wait ends the run here
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (wake_o === 1'b1) n_wake++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        @(posedge core_clk_i);
        while (pready_o !== 1'b1) @(posedge core_clk_i);
        rd_data = prdata_o;
        rd_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic chk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
        xfer(a, 1'b0, 32'h0);
        `CHK(nm, e, rd_data)
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : wt
    // slow source edges, two system clocks per level so none is missed
    task automatic edges(input logic lfo, input int n);
        repeat (2 * n)
        begin
            if (lfo) lfo_clk_i <= ~lfo_clk_i;
            else ext_clk_i <= ~ext_clk_i;
            wt(2);
        end
    endtask : edges
    initial
    begin
        wt(4);
        rst_n_i <= 1'b1;
        chk(timer_pkg::CTRL_OFF, 32'h0, "ctrl reset");
        chk(timer_pkg::CLKCFG_OFF, 32'h0, "clkcfg reset");
        // reserved alternate clock keeps the counter still meanwhile
        wr(timer_pkg::CTRL_OFF, 32'hfe);
        chk(timer_pkg::CTRL_OFF, 32'hfe, "ctrl rw");
        wr(timer_pkg::CTRL_OFF, 32'h00);
        chk(12'h01c, 32'h0, "unmapped");
        `CHK("unmapped err", 1'b1, rd_err)
        wr(timer_pkg::STATUS_OFF, 32'h3);
        chk(timer_pkg::STATUS_OFF, 32'h2, "status ro");
        $display("test registers done");
        wr(timer_pkg::RELOAD_LO_OFF, 32'h34);
        wr(timer_pkg::RELOAD_HI_OFF, 32'h12);
        wr(timer_pkg::COUNT_LO_OFF, 32'hfd);
        wr(timer_pkg::COUNT_HI_OFF, 32'hff);
        wr(timer_pkg::CLKCFG_OFF, 32'h5);
        wr(timer_pkg::CTRL_OFF, 32'h04);
        wt(20);
        chk(timer_pkg::CTRL_OFF, 32'hc4, "ovf flags");
        `CHK("irq ovf", 1'b1, irq_o)
        chk(timer_pkg::COUNT_HI_OFF, 32'h12, "reloaded hi");
        wr(timer_pkg::CTRL_OFF, 32'h04);
        wt(300);
        chk(timer_pkg::CTRL_OFF, 32'h44, "low wrap");
        `CHK("irq low off", 1'b0, irq_o)
        wr(timer_pkg::CTRL_OFF, 32'h64);
        `CHK("irq low on", 1'b1, irq_o)
        wr(timer_pkg::CTRL_OFF, 32'h00);
        $display("test sixteen bit done");
        wr(timer_pkg::COUNT_HI_OFF, 32'h77);
        wr(timer_pkg::COUNT_LO_OFF, 32'hfe);
        wr(timer_pkg::RELOAD_LO_OFF, 32'h80);
        wr(timer_pkg::CLKCFG_OFF, 32'h7);
        wr(timer_pkg::CTRL_OFF, 32'h08);
        wt(10);
        chk(timer_pkg::COUNT_HI_OFF, 32'h77, "hi gated");
        chk(timer_pkg::CTRL_OFF, 32'h48, "split low");
        `CHK("irq split low", 1'b0, irq_o)
        xfer(timer_pkg::COUNT_LO_OFF, 1'b0, 32'h0);
        `CHK("low own reload", 1'b1, rd_data[7])
        wr(timer_pkg::CTRL_OFF, 32'h0c);
        wt(200);
        xfer(timer_pkg::CTRL_OFF, 1'b0, 32'h0);
        `CHK("split hi flag", 1'b1, rd_data[7])
        `CHK("irq split hi", 1'b1, irq_o)
        wr(timer_pkg::CTRL_OFF, 32'h00);
        $display("test split done");
        wr(timer_pkg::CLKCFG_OFF, 32'h1);
        wr(timer_pkg::COUNT_LO_OFF, 32'h00);
        wr(timer_pkg::COUNT_HI_OFF, 32'h05);
        wr(timer_pkg::CTRL_OFF, 32'h14);
        edges(1'b1, 1);
        wt(6);
        chk(timer_pkg::CTRL_OFF, 32'h94, "capture flag");
        chk(timer_pkg::RELOAD_HI_OFF, 32'h05, "captured");
        wr(timer_pkg::CTRL_OFF, 32'h00);
        $display("test capture done");
        wr(timer_pkg::CLKCFG_OFF, 32'h0);
        wr(timer_pkg::COUNT_LO_OFF, 32'h00);
        wr(timer_pkg::COUNT_HI_OFF, 32'h00);
        wr(timer_pkg::CTRL_OFF, 32'h04);
        wt(120);
        wr(timer_pkg::CTRL_OFF, 32'h06);
        xfer(timer_pkg::COUNT_LO_OFF, 1'b0, 32'h0);
        d0 = rd_data;
        `CHK("div12", 1'b1, d0 >= 9 && d0 <= 11)
        wr(timer_pkg::CTRL_OFF, 32'h05);
        edges(1'b0, 80);
        wt(10);
        wr(timer_pkg::CTRL_OFF, 32'h07);
        chk(timer_pkg::COUNT_LO_OFF, d0 + 10, "ext div8");
        edges(1'b1, 16);
        lfo_div_one_i <= 1'b0;
        edges(1'b1, 16);
        wt(10);
        wr(timer_pkg::CTRL_OFF, 32'h06);
        chk(timer_pkg::COUNT_LO_OFF, d0 + 12, "lfo div8");
        lfo_div_one_i <= 1'b1;
        $display("test clock select done");
        wr(timer_pkg::COUNT_LO_OFF, 32'hf0);
        wr(timer_pkg::COUNT_HI_OFF, 32'hff);
        wr(timer_pkg::CLKCFG_OFF, 32'h5);
        suspend_i <= 1'b1;
        wr(timer_pkg::CTRL_OFF, 32'h04);
        wt(30);
        `CHK("wake count", 1, n_wake)
        // three counting edges around the read, then twenty frozen ones
        xfer(timer_pkg::COUNT_LO_OFF, 1'b0, 32'h0);
        d0 = rd_data;
        ce_i <= 1'b0;
        wt(20);
        ce_i <= 1'b1;
        chk(timer_pkg::COUNT_LO_OFF, d0 + 3, "ce freeze");
        // slow tick so the pending window is wide enough to probe
        wr(timer_pkg::CLKCFG_OFF, 32'h0);
        wr(timer_pkg::CTRL_OFF, 32'h00);
        other_wake_i <= 1'b1;
        wt(1);
        other_wake_i <= 1'b0;
        wt(2);
        `CHK("sync set", 1'b1, sync_pending_flag_o)
        xfer(timer_pkg::COUNT_LO_OFF, 1'b0, 32'h0);
        `CHK("sync refuse", 1'b1, rd_err)
        wt(60);
        `CHK("sync clear", 1'b0, sync_pending_flag_o)
        xfer(timer_pkg::COUNT_LO_OFF, 1'b0, 32'h0);
        `CHK("sync allow", 1'b0, rd_err)
        // raw external edges drive the counter while suspended
        wr(timer_pkg::COUNT_LO_OFF, 32'hff);
        wr(timer_pkg::COUNT_HI_OFF, 32'hff);
        wr(timer_pkg::CTRL_OFF, 32'h05);
        edges(1'b0, 8);
        wt(4);
        `CHK("raw ext wake", 2, n_wake)
        suspend_i <= 1'b0;
        $display("test suspend done");
        test_done();
    end
endmodule : testbench
bind auto_reload_timer_lfo_capture timer_properties timer_properties_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .lfo_div_one_i(lfo_div_one_i),
    .suspend_i(suspend_i), .other_wake_i(other_wake_i), .wake_o(wake_o),
    .sync_pending_flag_o(sync_pending_flag_o));
